// file: rtl/pin_mode_drive.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mode_drive
  import port_cfg_pkg::*;
(
  input wire logic [1:0] mode_i,
  input wire logic latch_i,
  output logic out_o,
  output logic oe_o,
  output logic weak_pullup_o
);
  pin_mode_t mode;
  assign mode = pin_mode_t'(mode_i);
  // drive value is low except push-pull with the latch high
  assign out_o = latch_i & (mode == MODE_PUSH_PULL);
  always_comb begin
    oe_o = 1'b0;
    weak_pullup_o = 1'b0;
    unique case (mode)
      MODE_QUASI: begin
        oe_o = ~latch_i;
        weak_pullup_o = latch_i;
      end
      MODE_PUSH_PULL: begin
        oe_o = 1'b1;
      end
      MODE_INPUT_ONLY: begin
        oe_o = 1'b0;
      end
      MODE_OPEN_DRAIN: begin
        oe_o = ~latch_i;
      end
    endcase
  end
endmodule // pin_mode_drive
`default_nettype wire

// file: rtl/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] agree;
  assign agree = ~(s2_q ^ s3_q);
  assign level_o = level_q;
  always_ff @(posedge clk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (rst_i) begin
      level_q <= {WIDTH{1'b1}};
    end else begin
      level_q <= (agree & s3_q) | (~agree & level_q);
    end
  end
endmodule // pin_sync3
`default_nettype wire

// file: rtl/port_cfg_pkg.sv
package port_cfg_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] KEYPAD_MASK_OFS = 8'h86;
  localparam logic [7:0] PORT2_MODE_ONE_OFS = 8'hA4;
  localparam logic [7:0] PORT2_MODE_TWO_OFS = 8'hA8;
  localparam logic [7:0] AUX_CONTROL_OFS = 8'hAC;
  localparam logic [7:0] POWER_CTRL_OFS = 8'hB0;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int P2_HYST_BIT = 7;
  localparam int P1_HYST_BIT = 6;
  localparam int P0_HYST_BIT = 5;
  localparam int CLK_OUT_EN_BIT = 4;
  localparam int T1_TOGGLE_BIT = 3;
  localparam int T0_TOGGLE_BIT = 2;
  localparam int KEYPAD_FLAG_BIT = 1;
  localparam int KEYPAD_IRQ_EN_BIT = 0;
  localparam int IDLE_BIT = 0;
  localparam int POWER_DOWN_BIT = 1;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CLK_OUT_DIV = 6;
  localparam int CLK_OUT_HALF = CLK_OUT_DIV / 2;
  // ------------------------------------------------------------
  // pin output modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_QUASI = 2'b00,
    MODE_PUSH_PULL = 2'b01,
    MODE_INPUT_ONLY = 2'b10,
    MODE_OPEN_DRAIN = 2'b11
  } pin_mode_t;
endpackage

// file: rtl/port_input_config_keypad_wake.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module port_input_config_keypad_wake
  import port_cfg_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // keypad port 0
  input wire logic [PIN_COUNT-1:0] port0_pin_i,
  // oscillator, timers and port 2 latches
  input wire logic rc_or_ext_clock_i,
  input wire logic timer0_toggle_i,
  input wire logic timer1_toggle_i,
  input wire logic [1:0] port2_latch_i,
  // pad controls
  output logic port0_hysteresis_sel_o,
  output logic port1_hysteresis_sel_o,
  output logic port2_hysteresis_sel_o,
  output logic clock_out_o,
  output logic clock_out_oe_o,
  output logic timer0_pin_o,
  output logic timer0_pin_oe_o,
  output logic timer1_pin_o,
  output logic timer1_pin_oe_o,
  output logic [1:0] port2_out_o,
  output logic [1:0] port2_oe_o,
  output logic [1:0] port2_weak_pullup_o,
  // core side
  output logic keypad_irq_o,
  output logic wake_o,
  output logic async_wake_o,
  output logic idle_o,
  output logic power_down_o
);
  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_width
    $error("PIN_COUNT must be 1 to 8");
  end
  // clock divider counts half periods in a 3-bit counter
  if (CLK_OUT_DIV < 2 || CLK_OUT_DIV % 2 != 0) begin : g_bad_div
    $error("CLK_OUT_DIV must be even and at least 2");
  end
  if (CLK_OUT_HALF > 8) begin : g_bad_half
    $error("CLK_OUT_HALF must fit the 3-bit divider");
  end
  // read words pack these fields at fixed low positions
  if (KEYPAD_FLAG_BIT != 1 || KEYPAD_IRQ_EN_BIT != 0) begin : g_bad_aux
    $error("aux_control_reg fields must sit at bits 1 and 0");
  end
  if (IDLE_BIT > 1 || POWER_DOWN_BIT > 1 || IDLE_BIT == POWER_DOWN_BIT) begin : g_bad_power
    $error("power control fields must be bits 0 and 1");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] keypad_pin_enable_mask_q;
  logic [7:0] port2_mode_one_q;
  logic [7:0] port2_mode_two_q;
  logic keypad_event_flag_q;
  logic keypad_event_flag_d;
  logic keypad_irq_en_q;
  logic [1:0] power_ctrl_q;
  logic [1:0] power_ctrl_d;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic [2:0] div_cnt_q;
  logic clk_div_q;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic req;
  logic hit_mask;
  logic hit_mode_one;
  logic hit_mode_two;
  logic hit_aux;
  logic hit_power;
  logic hit_any;
  logic wr_lane0;
  logic [31:0] rdata_d;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign hit_mask = (wb_adr_i == KEYPAD_MASK_OFS);
  assign hit_mode_one = (wb_adr_i == PORT2_MODE_ONE_OFS);
  assign hit_mode_two = (wb_adr_i == PORT2_MODE_TWO_OFS);
  assign hit_aux = (wb_adr_i == AUX_CONTROL_OFS);
  assign hit_power = (wb_adr_i == POWER_CTRL_OFS);
  assign hit_any = hit_mask | hit_mode_one | hit_mode_two | hit_aux | hit_power;
  assign wr_lane0 = req & hit_any & wb_we_i & wb_sel_i[0];

  logic [7:0] aux_read;
  assign aux_read = {6'h00, keypad_event_flag_q, keypad_irq_en_q};
  assign rdata_d = hit_mask ? {24'h000000, keypad_pin_enable_mask_q} :
                   hit_mode_one ? {24'h000000, port2_mode_one_q} :
                   hit_mode_two ? {24'h000000, port2_mode_two_q} :
                   hit_aux ? {24'h000000, aux_read} :
                   hit_power ? {30'h00000000, power_ctrl_q} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & hit_any;
      err_q <= req & ~hit_any;
      rdata_q <= rdata_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_pin_enable_mask_q <= REG_RESET;
      port2_mode_one_q <= REG_RESET;
      port2_mode_two_q <= REG_RESET;
      keypad_irq_en_q <= 1'b0;
    end else if (wr_lane0) begin
      if (hit_mask) begin
        keypad_pin_enable_mask_q <= wb_dat_i[7:0];
      end
      if (hit_mode_one) begin
        port2_mode_one_q <= wb_dat_i[7:0];
      end
      if (hit_mode_two) begin
        port2_mode_two_q <= wb_dat_i[7:0];
      end
      if (hit_aux) begin
        keypad_irq_en_q <= wb_dat_i[KEYPAD_IRQ_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // input hysteresis selection
  // ------------------------------------------------------------
  assign port2_hysteresis_sel_o = port2_mode_one_q[P2_HYST_BIT];
  assign port1_hysteresis_sel_o = port2_mode_one_q[P1_HYST_BIT];
  assign port0_hysteresis_sel_o = port2_mode_one_q[P0_HYST_BIT];

  // ------------------------------------------------------------
  // clock output divider
  // ------------------------------------------------------------
  logic clock_out_enable;
  logic div_wrap;
  assign clock_out_enable = port2_mode_one_q[CLK_OUT_EN_BIT] & rc_or_ext_clock_i;
  assign div_wrap = (div_cnt_q == 3'(CLK_OUT_HALF - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || !clock_out_enable) begin
      div_cnt_q <= 3'h0;
      clk_div_q <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_q <= 3'h0;
      clk_div_q <= ~clk_div_q;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end
  // runs in idle too: divider is not gated by idle
  assign clock_out_o = clk_div_q;
  assign clock_out_oe_o = clock_out_enable;

  // ------------------------------------------------------------
  // timer toggle outputs
  // ------------------------------------------------------------
  assign timer1_pin_oe_o = port2_mode_one_q[T1_TOGGLE_BIT];
  assign timer0_pin_oe_o = port2_mode_one_q[T0_TOGGLE_BIT];
  assign timer1_pin_o = timer1_toggle_i & timer1_pin_oe_o;
  assign timer0_pin_o = timer0_toggle_i & timer0_pin_oe_o;

  // ------------------------------------------------------------
  // port 2 pin output modes
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_p2
    pin_mode_drive u_drive (
      .mode_i({port2_mode_one_q[i], port2_mode_two_q[i]}),
      .latch_i(port2_latch_i[i]),
      .out_o(port2_out_o[i]),
      .oe_o(port2_oe_o[i]),
      .weak_pullup_o(port2_weak_pullup_o[i])
    );
  end

  // ------------------------------------------------------------
  // keypad detection
  // ------------------------------------------------------------
  logic [PIN_COUNT-1:0] port0_level;
  logic [PIN_COUNT-1:0] mask_used;
  logic key_low;
  logic key_low_async;
  pin_sync3 #(.WIDTH(PIN_COUNT)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port0_pin_i),
    .level_o(port0_level)
  );
  assign mask_used = keypad_pin_enable_mask_q[PIN_COUNT-1:0];
  assign key_low = |(mask_used & ~port0_level);
  assign key_low_async = |(mask_used & ~port0_pin_i);

  logic flag_clr;
  assign flag_clr = wr_lane0 & hit_aux & ~wb_dat_i[KEYPAD_FLAG_BIT];
  always_comb begin
    keypad_event_flag_d = keypad_event_flag_q;
    if (flag_clr) begin
      keypad_event_flag_d = 1'b0;
    end
    if (key_low) begin
      keypad_event_flag_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_event_flag_q <= 1'b0;
    end else begin
      keypad_event_flag_q <= keypad_event_flag_d;
    end
  end
  assign keypad_irq_o = keypad_event_flag_q & keypad_irq_en_q;

  // ------------------------------------------------------------
  // power state and wake
  // ------------------------------------------------------------
  always_comb begin
    power_ctrl_d = power_ctrl_q;
    if (wr_lane0 && hit_power) begin
      power_ctrl_d = wb_dat_i[1:0];
    end
    if (keypad_irq_o) begin
      power_ctrl_d = 2'b00;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_ctrl_q <= 2'b00;
    end else begin
      power_ctrl_q <= power_ctrl_d;
    end
  end
  assign idle_o = power_ctrl_q[IDLE_BIT];
  assign power_down_o = power_ctrl_q[POWER_DOWN_BIT];
  assign wake_o = keypad_irq_o & (idle_o | power_down_o);
  assign async_wake_o = key_low_async & keypad_irq_en_q & power_down_o;
endmodule // port_input_config_keypad_wake
`default_nettype wire

// file: tb/keypad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// keypad on port 0: switches to ground, pull-ups on every line
// ------------------------------------------------------------
module keypad_model (
  input wire logic [7:0] key_down_i,
  output logic [7:0] pin_o
);
  // a released key leaves the line at its pull-up level
  assign pin_o = ~key_down_i;
endmodule // keypad_model
`default_nettype wire

// file: tb/port_cfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module port_cfg_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic rc_or_ext_clock_i,
  input wire logic clock_out_o,
  input wire logic clock_out_oe_o,
  input wire logic timer0_toggle_i,
  input wire logic timer0_pin_o,
  input wire logic timer0_pin_oe_o,
  input wire logic keypad_irq_o,
  input wire logic wake_o,
  input wire logic async_wake_o,
  input wire logic idle_o,
  input wire logic power_down_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_err_one_pulse: assert property (wb_err_o |=> !wb_err_o && !wb_ack_o) else $error("err not a lone pulse");
  chk_err_no_ack: assert property (wb_err_o |-> !wb_ack_o) else $error("err and ack together");
  chk_clkout_low_phase: assert property ($rose(clock_out_o) && $past(clock_out_o, 4) |->
    !$past(clock_out_o, 2) && !$past(clock_out_o, 3)) else $error("clock out low phase wrong");
  chk_clkout_needs_rc: assert property (clock_out_oe_o |-> rc_or_ext_clock_i) else $error("clock out without rc");
  chk_timer_gate: assert property (timer0_pin_o == (timer0_toggle_i && timer0_pin_oe_o))
    else $error("timer pin not gated");
  chk_flag_sticky: assert property (keypad_irq_o && !(wb_stb_i && wb_we_i) |=> keypad_irq_o)
    else $error("irq dropped without write");
  chk_wake_on_irq: assert property (keypad_irq_o && (idle_o || power_down_o) |->
    wake_o ##1 (!idle_o && !power_down_o)) else $error("no wake on irq");
  chk_async_pd_only: assert property (async_wake_o |-> power_down_o) else $error("async wake awake");
endmodule // port_cfg_chk
bind port_input_config_keypad_wake port_cfg_chk u_chk (.clk_i, .rst_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_err_o, .rc_or_ext_clock_i, .clock_out_o, .clock_out_oe_o, .timer0_toggle_i, .timer0_pin_o,
  .timer0_pin_oe_o, .keypad_irq_o, .wake_o, .async_wake_o, .idle_o, .power_down_o);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import port_cfg_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, key_down = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, rc_or_ext_clock_i = 0, timer0_toggle_i = 0, timer1_toggle_i = 0;
  logic [1:0] port2_latch_i = 2'b00, port2_out_o, port2_oe_o, port2_weak_pullup_o;
  logic [7:0] port0_pin_i;
  logic port0_hysteresis_sel_o, port1_hysteresis_sel_o, port2_hysteresis_sel_o, clock_out_o, clock_out_oe_o;
  logic timer0_pin_o, timer0_pin_oe_o, timer1_pin_o, timer1_pin_oe_o, keypad_irq_o, wake_o, async_wake_o;
  logic idle_o, power_down_o, e, sa, sw;
  int err_total = 0, total_checks = 0, n;
  always #25 clk_i = ~clk_i;
  keypad_model kp (.key_down_i(key_down), .pin_o(port0_pin_i));
  port_input_config_keypad_wake uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port0_pin_i, .rc_or_ext_clock_i, .timer0_toggle_i,
    .timer1_toggle_i, .port2_latch_i, .port0_hysteresis_sel_o, .port1_hysteresis_sel_o,
    .port2_hysteresis_sel_o, .clock_out_o, .clock_out_oe_o, .timer0_pin_o, .timer0_pin_oe_o, .timer1_pin_o,
    .timer1_pin_oe_o, .port2_out_o, .port2_oe_o, .port2_weak_pullup_o, .keypad_irq_o, .wake_o,
    .async_wake_o, .idle_o, .power_down_o);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    wb(0, KEYPAD_MASK_OFS, 0); check(rd, 32'h0); check(e, 0);
    wb(0, PORT2_MODE_ONE_OFS, 0); check(rd, 32'h0);
    wb(0, 8'h10, 0); check(e, 1);
    wb(1, KEYPAD_MASK_OFS, 8'hA5); wb(0, KEYPAD_MASK_OFS, 0); check(rd, 32'hA5);
    for (int b = 5; b < 8; b++) begin
      wb(1, PORT2_MODE_ONE_OFS, 8'h1 << b);
      check({port2_hysteresis_sel_o, port1_hysteresis_sel_o, port0_hysteresis_sel_o}, 3'b1 << (b - 5));
    end
    $display("test regs done");
  endtask
  task automatic t_pins;
    rc_or_ext_clock_i <= 1; timer0_toggle_i <= 1; timer1_toggle_i <= 1;
    wb(1, PORT2_MODE_ONE_OFS, 8'h1C); check(clock_out_oe_o, 1);
    check({timer1_pin_o, timer1_pin_oe_o, timer0_pin_o, timer0_pin_oe_o}, 4'hF);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      sa = clock_out_o; @(posedge clk_i); if (clock_out_o && !sa) n++;
    end
    check(n, 10);
    rc_or_ext_clock_i <= 0; @(posedge clk_i); @(posedge clk_i); check(clock_out_oe_o, 0);
    for (int c = 0; c < 8; c++) begin
      port2_latch_i <= {2{c[2]}};
      wb(1, PORT2_MODE_ONE_OFS, {6'h0, {2{c[1]}}}); wb(1, PORT2_MODE_TWO_OFS, {6'h0, {2{c[0]}}});
      check(port2_oe_o, {2{c[1:0] == 1 || (c[1:0] != 2 && !c[2])}});
      check(port2_out_o, {2{c[1:0] == 1 && c[2]}});
      check(port2_weak_pullup_o, {2{c[1:0] == 0 && c[2]}});
    end
    $display("test pins done");
  endtask
  task automatic t_keypad;
    wb(1, KEYPAD_MASK_OFS, 8'h04); wb(1, AUX_CONTROL_OFS, 8'h01);
    key_down <= 8'h08; repeat (10) @(posedge clk_i); check(keypad_irq_o, 0);
    key_down <= 8'h04; repeat (10) @(posedge clk_i); check(keypad_irq_o, 1);
    key_down <= 8'h00; repeat (10) @(posedge clk_i); check(keypad_irq_o, 1);
    wb(1, AUX_CONTROL_OFS, 8'h03); wb(0, AUX_CONTROL_OFS, 0); check(rd, 32'h3);
    wb(1, AUX_CONTROL_OFS, 8'h01); check(keypad_irq_o, 0);
    for (int m = 1; m < 3; m++) begin
      wb(1, POWER_CTRL_OFS, m[7:0]); sa = 0; sw = 0;
      check({power_down_o, idle_o}, m[1:0]);
      key_down <= 8'h04;
      for (int i = 0; i < 20; i++) begin
        @(posedge clk_i); sa |= async_wake_o; sw |= wake_o;
      end
      check(sw, 1); check(sa, m == 2); check({idle_o, power_down_o}, 0);
      key_down <= 8'h00; repeat (8) @(posedge clk_i); wb(1, AUX_CONTROL_OFS, 8'h01);
    end
    $display("test keypad done");
  endtask
  task automatic t_reset;
    wb(1, KEYPAD_MASK_OFS, 8'hFF); wb(1, PORT2_MODE_ONE_OFS, 8'hE0); wb(1, POWER_CTRL_OFS, 8'h01);
    rst_i <= 1; repeat (4) @(posedge clk_i); rst_i <= 0;
    check({port2_hysteresis_sel_o, port1_hysteresis_sel_o, port0_hysteresis_sel_o, idle_o}, 0);
    wb(0, KEYPAD_MASK_OFS, 0); check(rd, 32'h0);
    wb(0, AUX_CONTROL_OFS, 0); check(rd, 32'h0);
    $display("test reset done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_regs; t_pins; t_keypad; t_reset;
    summarize;
  end
  initial begin
    #2000000;
    err_total++;
    summarize;
  end
endmodule // tb_top
`default_nettype wire
